/* File: logic/t16pwm_pkg.sv */
`default_nettype none
package t16pwm_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [4:0]  ADDR_CTRL   = 5'h00;  // Mode, outputs, clock
  localparam logic [4:0]  ADDR_COUNT  = 5'h04;  // counter_value
  localparam logic [4:0]  ADDR_CMPA   = 5'h08;  // compare_value_a buffer
  localparam logic [4:0]  ADDR_CMPB   = 5'h0c;  // compare_value_b buffer
  localparam logic [4:0]  ADDR_CAPTOP = 5'h10;  // capture_top_register
  localparam logic [4:0]  ADDR_FLAGS  = 5'h14;  // Flags, write one to clear
  // ==========================================================
  // Control word layout
  typedef struct packed {
    logic [2:0] rsv;   // Reads as zero
    logic       dirb;  // output_pin_direction_bit, channel B
    logic       dira;  // output_pin_direction_bit, channel A
    logic [2:0] cs;    // Prescaler select
    logic [1:0] comb;  // compare_output_mode, channel B
    logic [1:0] coma;  // output_a_mode
    logic [3:0] mode;  // waveform_mode_select
  } t16pwm_ctrl_s;
  // Flag bit positions
  localparam int FLG_OVF  = 0;  // overflow_flag
  localparam int FLG_CMPA = 1;  // Compare flag A
  localparam int FLG_CMPB = 2;  // Compare flag B
  localparam int FLG_CAP  = 3;  // capture_flag
  // ==========================================================
  // Waveform modes
  localparam logic [3:0] WGM_PC8   = 4'h1;
  localparam logic [3:0] WGM_PC9   = 4'h2;
  localparam logic [3:0] WGM_PC10  = 4'h3;
  localparam logic [3:0] WGM_FP8   = 4'h5;
  localparam logic [3:0] WGM_FP9   = 4'h6;
  localparam logic [3:0] WGM_FP10  = 4'h7;
  localparam logic [3:0] WGM_PCCAP = 4'ha;
  localparam logic [3:0] WGM_PCOCA = 4'hb;
  localparam logic [3:0] WGM_FPCAP = 4'he;
  localparam logic [3:0] WGM_FPOCA = 4'hf;
  // Output modes
  localparam logic [1:0] COM_OFF  = 2'h0;
  localparam logic [1:0] COM_TGL  = 2'h1;
  localparam logic [1:0] COM_NINV = 2'h2;
  localparam logic [1:0] COM_INV  = 2'h3;
  // Counter values
  localparam logic [15:0] TOP8   = 16'h00ff;
  localparam logic [15:0] TOP9   = 16'h01ff;
  localparam logic [15:0] TOP10  = 16'h03ff;
  localparam logic [15:0] MAXV   = 16'hffff;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] ONE16  = 16'h0001;
  // ==========================================================
  // Prescaler selects and divider masks
  localparam logic [2:0] CS_1    = 3'h1;
  localparam logic [2:0] CS_8    = 3'h2;
  localparam logic [2:0] CS_64   = 3'h3;
  localparam logic [2:0] CS_256  = 3'h4;
  localparam logic [2:0] CS_1024 = 3'h5;
  localparam logic [9:0] PS_M8    = 10'h007;
  localparam logic [9:0] PS_M64   = 10'h03f;
  localparam logic [9:0] PS_M256  = 10'h0ff;
  localparam logic [9:0] PS_M1024 = 10'h3ff;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: logic/t16pwm_top.sv */
// Summary of operation
// - Fast modes count up, restart at zero
// - Fast TOP: fixed, capture or compare A
// - Fast: clear on match, set at zero
// - Fast: overflow and TOP flag at TOP
// - Fast: compare A loads from buffer at TOP
// - Capture TOP unbuffered; low write wraps counter
// - Fixed TOP masks compare writes to resolution
// - Zero gives spike, TOP gives constant level
// - Output A mode 1 toggles on match
// - Every match sets that channel's flag
// - Dual slope: up, one TOP cycle, down
// - Dual slope TOP: fixed, capture or A
// - Dual slope: clear rising, set falling
// - Dual slope: overflow at zero, TOP flag
// - Dual slope loads compare only at TOP
// - Dual slope extremes give constant levels
// - Modes 2/3 pick polarity; direction gates pin
// - Variable TOP from 0x0003 to 16 bits
// - Output mode zero leaves output untouched
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module t16pwm_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             pin_a_out,
  output logic             pin_a_oe_n,
  output logic             pin_b_out,
  output logic             pin_b_oe_n
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [9:0]              presc;    // Prescaler count
    logic [15:0]             cnt;      // counter_value
    logic                    up;       // Dual slope direction
    t16pwm_pkg::t16pwm_ctrl_s ctrl;    // Control word
    logic [15:0]             ocra_buf; // Written compare A
    logic [15:0]             ocrb_buf; // Written compare B
    logic [15:0]             ocra;     // Active compare A
    logic [15:0]             ocrb;     // Active compare B
    logic [15:0]             cap;      // capture_top_register
    logic [3:0]              flags;    // Sticky flags
    logic                    oca;      // compare_output_a
    logic                    ocb;      // compare_output_b
    logic                    pa;       // Pin A level
    logic                    pa_oe_n;  // Pin A enable, low drives
    logic                    pb;       // Pin B level
    logic                    pb_oe_n;  // Pin B enable, low drives
    logic                    aw_have;  // Address held
    logic [4:0]              awaddr;
    logic                    w_have;   // Data held
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
  } t16pwm_state_s;

  // Pins stay released while reset holds
  localparam t16pwm_state_s S_RST = '{pa_oe_n: 1'b1, pb_oe_n: 1'b1, default: '0};

  t16pwm_state_s s_q;
  t16pwm_state_s s_d;

  // ==========================================================
  // Helpers
  function automatic logic is_fast(input logic [3:0] m);
    return m inside {t16pwm_pkg::WGM_FP8, t16pwm_pkg::WGM_FP9, t16pwm_pkg::WGM_FP10,
                     t16pwm_pkg::WGM_FPCAP, t16pwm_pkg::WGM_FPOCA};
  endfunction

  function automatic logic is_pc(input logic [3:0] m);
    return m inside {t16pwm_pkg::WGM_PC8, t16pwm_pkg::WGM_PC9, t16pwm_pkg::WGM_PC10,
                     t16pwm_pkg::WGM_PCCAP, t16pwm_pkg::WGM_PCOCA};
  endfunction

  // Resolution mask; all ones outside fixed modes
  function automatic logic [15:0] fixed_mask(input logic [3:0] m);
    case (m)
      t16pwm_pkg::WGM_FP8, t16pwm_pkg::WGM_PC8:   return t16pwm_pkg::TOP8;
      t16pwm_pkg::WGM_FP9, t16pwm_pkg::WGM_PC9:   return t16pwm_pkg::TOP9;
      t16pwm_pkg::WGM_FP10, t16pwm_pkg::WGM_PC10: return t16pwm_pkg::TOP10;
      default:                                    return t16pwm_pkg::MAXV;
    endcase
  endfunction

  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] c,
                                         input logic [15:0] a);
    case (m)
      t16pwm_pkg::WGM_FPCAP, t16pwm_pkg::WGM_PCCAP: return c;
      t16pwm_pkg::WGM_FPOCA, t16pwm_pkg::WGM_PCOCA: return a;
      default:                                      return fixed_mask(m);
    endcase
  endfunction

  // Timer clock enable from the free running prescaler
  function automatic logic presc_tick(input logic [2:0] cs, input logic [9:0] p);
    case (cs)
      t16pwm_pkg::CS_1:    return 1'b1;
      t16pwm_pkg::CS_8:    return (p & t16pwm_pkg::PS_M8) == t16pwm_pkg::PS_M8;
      t16pwm_pkg::CS_64:   return (p & t16pwm_pkg::PS_M64) == t16pwm_pkg::PS_M64;
      t16pwm_pkg::CS_256:  return (p & t16pwm_pkg::PS_M256) == t16pwm_pkg::PS_M256;
      t16pwm_pkg::CS_1024: return p == t16pwm_pkg::PS_M1024;
      default:             return 1'b0;
    endcase
  endfunction

  // Byte lane merge of the low half word
  function automatic logic [15:0] merge16(input logic [15:0] o, input logic [31:0] d,
                                          input logic [3:0] st);
    logic [15:0] r;
    r = o;
    if (st[0]) begin
      r[7:0] = d[7:0];
    end
    if (st[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // Next compare output level for one channel
  function automatic logic oc_next(input logic [1:0] com, input logic oc, input logic tgl_ok,
                                   input logic fast, input logic pc, input logic match,
                                   input logic at_top, input logic rising);
    logic lvl;
    lvl = (com == t16pwm_pkg::COM_INV);
    if (com == t16pwm_pkg::COM_OFF) begin
      return oc;
    end else if (com == t16pwm_pkg::COM_TGL) begin
      return (tgl_ok && match) ? ~oc : oc;
    end else if (fast) begin
      // Zero-side action wins at TOP, so compare equal to TOP stays constant
      if (at_top) begin
        return ~lvl;
      end
      return match ? lvl : oc;
    end else if (pc) begin
      if (match) begin
        return rising ? lvl : ~lvl;
      end
      return oc;
    end
    return oc;
  endfunction

  // ==========================================================
  // Combinational view
  logic        tick;     // Timer clock enable
  logic        fast_m;   // Single slope mode
  logic        pc_m;     // Dual slope mode
  logic [15:0] top;      // Current TOP
  logic        at_top;   // Counter equals TOP
  logic        rising;   // Effective dual slope direction
  logic        match_a;
  logic        match_b;
  logic        do_wr;    // Write performed this cycle
  logic        wr_cnt;
  logic        wr_cap;
  logic        wr_cmpa;
  logic [15:0] wr_val;   // Merged write value
  logic [15:0] fmask;
  logic [3:0]  fset;
  logic [3:0]  fclr;

  always_comb begin
    tick    = presc_tick(s_q.ctrl.cs, s_q.presc);
    fast_m  = is_fast(s_q.ctrl.mode);
    pc_m    = is_pc(s_q.ctrl.mode);
    top     = top_of(s_q.ctrl.mode, s_q.cap, s_q.ocra);
    at_top  = s_q.cnt == top;
    // Counter at zero counts as rising, at TOP as falling
    rising  = (s_q.cnt == t16pwm_pkg::ZERO16) || (s_q.up && !at_top);
    match_a = s_q.cnt == s_q.ocra;
    match_b = s_q.cnt == s_q.ocrb;
    fmask   = fixed_mask(s_q.ctrl.mode);
    do_wr   = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    wr_cnt  = do_wr && (s_q.awaddr == t16pwm_pkg::ADDR_COUNT);
    wr_cap  = do_wr && (s_q.awaddr == t16pwm_pkg::ADDR_CAPTOP);
    wr_cmpa = do_wr && (s_q.awaddr == t16pwm_pkg::ADDR_CMPA);
    wr_val  = t16pwm_pkg::ZERO16;
    fset    = '0;
    fclr    = '0;
    s_d     = s_q;
    s_d.presc = s_q.presc + 10'h001;

    // ========================================================
    // Counter, buffers and flags
    if (tick) begin
      if (fast_m) begin
        if (at_top) begin
          s_d.cnt  = t16pwm_pkg::ZERO16;
          s_d.ocra = s_q.ocra_buf;
          s_d.ocrb = s_q.ocrb_buf;
          fset[t16pwm_pkg::FLG_OVF] = 1'b1;
        end else begin
          // Capture TOP below count runs on through 0xffff
          s_d.cnt = s_q.cnt + t16pwm_pkg::ONE16;
        end
      end else if (pc_m) begin
        if (s_q.up) begin
          if (at_top) begin
            s_d.up   = 1'b0;
            s_d.cnt  = s_q.cnt - t16pwm_pkg::ONE16;
            s_d.ocra = s_q.ocra_buf;
            s_d.ocrb = s_q.ocrb_buf;
          end else begin
            s_d.cnt = s_q.cnt + t16pwm_pkg::ONE16;
          end
        end else if (s_q.cnt == t16pwm_pkg::ZERO16) begin
          s_d.up  = 1'b1;
          s_d.cnt = t16pwm_pkg::ONE16;
          fset[t16pwm_pkg::FLG_OVF] = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - t16pwm_pkg::ONE16;
        end
      end else begin
        // Other modes: plain wrapping count
        s_d.cnt = s_q.cnt + t16pwm_pkg::ONE16;
        fset[t16pwm_pkg::FLG_OVF] = s_q.cnt == t16pwm_pkg::MAXV;
      end
      // Flag of the register that defines TOP
      if (at_top && (fast_m || pc_m)) begin
        if (top_of(s_q.ctrl.mode, t16pwm_pkg::ZERO16, t16pwm_pkg::MAXV) == t16pwm_pkg::ZERO16) begin
          fset[t16pwm_pkg::FLG_CAP] = 1'b1;
        end
      end
      fset[t16pwm_pkg::FLG_CMPA] = match_a;
      fset[t16pwm_pkg::FLG_CMPB] = match_b;
      s_d.oca = oc_next(s_q.ctrl.coma, s_q.oca, 1'b1, fast_m, pc_m, match_a, at_top, rising);
      s_d.ocb = oc_next(s_q.ctrl.comb, s_q.ocb, 1'b0, fast_m, pc_m, match_b, at_top, rising);
    end
    // Without double buffering the written value is active at once
    if (!fast_m && !pc_m) begin
      s_d.ocra = s_q.ocra_buf;
      s_d.ocrb = s_q.ocrb_buf;
    end

    // ========================================================
    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (do_wr) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = t16pwm_pkg::RESP_OKAY;
      case (s_q.awaddr)
        t16pwm_pkg::ADDR_CTRL: begin
          wr_val = merge16(s_q.ctrl, s_q.wdata, s_q.wstrb);
          s_d.ctrl = t16pwm_pkg::t16pwm_ctrl_s'(wr_val);
          s_d.ctrl.rsv = '0;
        end
        t16pwm_pkg::ADDR_COUNT: begin
          wr_val = merge16(s_q.cnt, s_q.wdata, s_q.wstrb);
          s_d.cnt = wr_val;                        // Software write beats counting
        end
        t16pwm_pkg::ADDR_CMPA: begin
          wr_val = merge16(s_q.ocra_buf, s_q.wdata, s_q.wstrb);
          s_d.ocra_buf = wr_val & fmask;
        end
        t16pwm_pkg::ADDR_CMPB: begin
          wr_val = merge16(s_q.ocrb_buf, s_q.wdata, s_q.wstrb);
          s_d.ocrb_buf = wr_val & fmask;
        end
        t16pwm_pkg::ADDR_CAPTOP: begin
          wr_val = merge16(s_q.cap, s_q.wdata, s_q.wstrb);
          s_d.cap = wr_val;
        end
        t16pwm_pkg::ADDR_FLAGS: begin
          fclr = s_q.wstrb[0] ? s_q.wdata[3:0] : 4'h0;
        end
        default: begin
          s_d.bresp = t16pwm_pkg::RESP_SLVERR;
        end
      endcase
    end
    // A flag set in the clearing cycle survives
    s_d.flags = (s_q.flags & ~fclr) | fset;
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;

    // ========================================================
    // Read channel, one outstanding read
    if (s_axi_arvalid && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rresp   = t16pwm_pkg::RESP_OKAY;
      s_d.rdata   = '0;
      case (s_axi_araddr)
        t16pwm_pkg::ADDR_CTRL:   s_d.rdata[15:0] = s_q.ctrl;
        t16pwm_pkg::ADDR_COUNT:  s_d.rdata[15:0] = s_q.cnt;
        t16pwm_pkg::ADDR_CMPA:   s_d.rdata[15:0] = s_q.ocra_buf;
        t16pwm_pkg::ADDR_CMPB:   s_d.rdata[15:0] = s_q.ocrb_buf;
        t16pwm_pkg::ADDR_CAPTOP: s_d.rdata[15:0] = s_q.cap;
        t16pwm_pkg::ADDR_FLAGS:  s_d.rdata[3:0]  = s_q.flags;
        default:                 s_d.rresp       = t16pwm_pkg::RESP_SLVERR;
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end else if (!s_q.rvalid) begin
      s_d.arready = 1'b1;
    end

    // ========================================================
    // Pins follow the output registers when enabled
    s_d.pa      = s_d.oca;
    s_d.pb      = s_d.ocb;
    s_d.pa_oe_n = !(s_d.ctrl.dira && (s_d.ctrl.coma != t16pwm_pkg::COM_OFF));
    s_d.pb_oe_n = !(s_d.ctrl.dirb && (s_d.ctrl.comb != t16pwm_pkg::COM_OFF));
  end

  // ==========================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign pin_a_out     = s_q.pa;
  assign pin_a_oe_n    = s_q.pa_oe_n;
  assign pin_b_out     = s_q.pb;
  assign pin_b_oe_n    = s_q.pb_oe_n;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_fast_count_up: assert property (
    tick && fast_m && !at_top && !wr_cnt |=> s_q.cnt == $past(s_q.cnt) + t16pwm_pkg::ONE16)
    else $error("fast count did not step up");
  chk_fast_top_clear: assert property (
    tick && fast_m && at_top && !wr_cnt |=> s_q.cnt == t16pwm_pkg::ZERO16)
    else $error("fast count not cleared after TOP");
  chk_fast_set_zero: assert property (
    tick && fast_m && at_top && s_q.ctrl.coma == t16pwm_pkg::COM_NINV |=> s_q.oca && s_q.pa)
    else $error("non-inverted output not set at zero");
  chk_fast_ovf_flag: assert property (
    tick && fast_m && at_top |=> s_q.flags[t16pwm_pkg::FLG_OVF])
    else $error("overflow flag missing at TOP");
  chk_buf_load: assert property (
    tick && fast_m && at_top |=> s_q.ocra == $past(s_q.ocra_buf))
    else $error("compare A not loaded at TOP");
  chk_cap_direct: assert property (
    wr_cap |=> s_q.cap == $past(wr_val))
    else $error("capture TOP not written at once");
  chk_fixed_mask: assert property (
    wr_cmpa |=> (s_q.ocra_buf & ~$past(fmask)) == t16pwm_pkg::ZERO16)
    else $error("compare bits above resolution kept");
  chk_toggle_a: assert property (
    tick && fast_m && match_a && s_q.ctrl.coma == t16pwm_pkg::COM_TGL |=> s_q.oca != $past(s_q.oca))
    else $error("output A did not toggle");
  chk_cmp_flag: assert property (
    tick && match_b |=> s_q.flags[t16pwm_pkg::FLG_CMPB])
    else $error("compare flag B missing on match");
  chk_pc_turn: assert property (
    tick && pc_m && s_q.up && at_top && !wr_cnt |=> !s_q.up && s_q.cnt == $past(s_q.cnt) - t16pwm_pkg::ONE16)
    else $error("dual slope did not turn at TOP");
  chk_pc_match_up: assert property (
    tick && pc_m && match_a && rising && s_q.ctrl.coma == t16pwm_pkg::COM_NINV |=> !s_q.oca)
    else $error("rising match did not clear output");
  chk_pc_ovf_zero: assert property (
    tick && pc_m && !s_q.up && s_q.cnt == t16pwm_pkg::ZERO16 |=> s_q.flags[t16pwm_pkg::FLG_OVF])
    else $error("overflow flag missing at zero");
  chk_pc_hold_cmp: assert property (
    pc_m && !(tick && s_q.up && at_top) |=> $stable(s_q.ocra))
    else $error("compare A changed away from TOP");
  chk_pin_enable: assert property (
    s_q.pa_oe_n == !(s_q.ctrl.dira && s_q.ctrl.coma != t16pwm_pkg::COM_OFF))
    else $error("pin A enable wrong");

  cov_fast_wrap: cover property (tick && fast_m && at_top);
  cov_pc_turn: cover property (tick && pc_m && s_q.up && at_top);
  cov_flag_clear_race: cover property (do_wr && |(fclr & fset));
endmodule
`default_nettype wire

/* File: tb/tb_timer16_fast_and_phase_pwm.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_timer16_fast_and_phase_pwm;
  // ==========================================
  // Bench state; every input has a value at time zero
  logic        aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0;
  logic        bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic        awr, wrd, bv, arr, rvl, pa, pa_oe_n, pb, pb_oe_n;
  logic [4:0]  awa = '0, ara = '0;
  logic [31:0] wd = '0, rdat, rv;
  logic [1:0]  br, rr;
  int          n_fail = 0, n_checks = 0, hi, lo;
  t16pwm_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h3),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rvl), .s_axi_rready(rry),
    .pin_a_out(pa), .pin_a_oe_n(pa_oe_n), .pin_b_out(pb), .pin_b_oe_n(pb_oe_n));
  // ==========================================
  // Verdict, comparison and bounded stepping
  task automatic final_report;
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A hang ends the run instead of stalling it
  task automatic step(inout int t, input logic neg);
    if (neg) @(negedge aclk);
    else @(posedge aclk);
    t++;
    if (t > 6000) begin
      n_fail++;
      final_report();
    end
  endtask
  // ==========================================
  // AXI4-Lite master: payload held until its own ready is seen
  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [1:0] e = 2'h0);
    int t;
    logic ad, dd;
    t = 0;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    awa <= a;
    wd <= {16'h0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!(ad && dd)) begin
      step(t, 1'b0);
      if (awr === 1'b1 && !ad) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (wrd === 1'b1 && !dd) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end
    while (bv !== 1'b1) step(t, 1'b0);
    bry <= 1'b0;
    cmp("bresp", {30'h0, e}, {30'h0, br});
  endtask
  task automatic rd(input logic [4:0] a, input logic [1:0] e = 2'h0);
    int t;
    t = 0;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      step(t, 1'b0);
      if (arr === 1'b1) arv <= 1'b0;
    end while (rvl !== 1'b1);
    rry <= 1'b0;
    rv = rdat;
    cmp("rresp", {30'h0, e}, {30'h0, rr});
  endtask
  // ==========================================
  // Timer helpers; compare A is loaded while stopped, in mode 0 except in mask, which loads it in the mode under test
  task automatic setup(input logic [3:0] m, input logic [1:0] c, input logic [2:0] s,
                       input logic [15:0] ca, input logic [15:0] ct, input logic d);
    wr(t16pwm_pkg::ADDR_CTRL, 16'h0000);
    wr(t16pwm_pkg::ADDR_CMPA, ca);
    wr(t16pwm_pkg::ADDR_CAPTOP, ct);
    wr(t16pwm_pkg::ADDR_COUNT, 16'h0000);
    wr(t16pwm_pkg::ADDR_CTRL, {3'h0, 1'b0, d, s, 2'h0, c, m});
  endtask
  // Output A sampled mid-cycle; counts clocks until it reaches a level
  task automatic pin(input logic v, output int n);
    n = 0;
    while (pa !== v) step(n, 1'b1);
  endtask
  // The first period after start is skipped, the next one is timed
  task automatic pwm(input logic [3:0] m, input logic [1:0] c, input logic [2:0] s,
                     input logic [15:0] ca, input logic [15:0] ct, input int eh, input int el);
    int x;
    setup(m, c, s, ca, ct, 1'b1);
    pin(1'b0, x);
    pin(1'b1, x);
    pin(1'b0, hi);
    pin(1'b1, lo);
    cmp("high time", eh, hi);
    cmp("low time", el, lo);
  endtask
  task automatic flat(input logic [3:0] m, input logic [1:0] c, input logic [15:0] ca,
                      input logic v);
    int bad;
    bad = 0;
    setup(m, c, 3'h1, ca, 16'h0000, 1'b1);
    repeat (600) @(negedge aclk);
    repeat (1100) begin
      @(negedge aclk);
      if (pa !== v) bad++;
    end
    cmp("steady level", 0, bad);
  endtask
  task automatic oe(input logic [1:0] c, input logic d, input logic e);
    setup(4'h5, c, 3'h0, 16'h0040, 16'h0000, d);
    repeat (3) @(negedge aclk);
    cmp("pin enable", {31'h0, e}, {31'h0, pa_oe_n});
    cmp("pin b enable", 1, {31'h0, pb_oe_n});
    cmp("pin b level", 0, {31'h0, pb});
  endtask
  task automatic mask(input logic [3:0] m, input logic [15:0] e);
    wr(t16pwm_pkg::ADDR_CTRL, {12'h000, m});
    wr(t16pwm_pkg::ADDR_CMPA, 16'hffff);
    rd(t16pwm_pkg::ADDR_CMPA);
    cmp("masked compare", {16'h0, e}, rv);
  endtask
  // Short run stopped, flags cleared by ones, run again, flags read
  task automatic flags(input logic [3:0] m);
    setup(m, 2'h2, 3'h1, 16'h0001, 16'h0003, 1'b1);
    wr(t16pwm_pkg::ADDR_CTRL, {12'h000, m});
    wr(t16pwm_pkg::ADDR_FLAGS, 16'h000f);
    rd(t16pwm_pkg::ADDR_FLAGS);
    cmp("flags cleared", 32'h0, rv);
    wr(t16pwm_pkg::ADDR_CTRL, {5'h00, 3'h1, 2'h0, 2'h2, m});
    repeat (20) @(posedge aclk);
    wr(t16pwm_pkg::ADDR_CTRL, {12'h000, m});
    rd(t16pwm_pkg::ADDR_FLAGS);
    cmp("flags set", 32'h0000000f, rv);
  endtask
  // Capture TOP acts at once; a count above TOP runs on through 0xffff
  task automatic cap_top;
    setup(4'he, 2'h2, 3'h1, 16'h0001, 16'h0003, 1'b1);
    wr(t16pwm_pkg::ADDR_CAPTOP, 16'h0100);
    repeat (10) @(posedge aclk);
    rd(t16pwm_pkg::ADDR_COUNT);
    cmp("count past old top", 1, {31'h0, rv[15:0] > 16'h0003 && rv[15:0] < 16'h0100});
    wr(t16pwm_pkg::ADDR_COUNT, 16'hfff0);
    rd(t16pwm_pkg::ADDR_COUNT);
    cmp("count above top", 32'hf, {28'h0, rv[15:12]});
    repeat (40) @(posedge aclk);
    rd(t16pwm_pkg::ADDR_COUNT);
    cmp("count wrapped", 32'h0, {24'h0, rv[15:8]});
  endtask
  // ==========================================
  // Clock and main sequence
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    cmp("pin enable reset", 1, {31'h0, pa_oe_n});
    rd(t16pwm_pkg::ADDR_CTRL);
    cmp("ctrl reset", 0, rv);
    rd(5'h18, t16pwm_pkg::RESP_SLVERR);
    wr(5'h18, 16'h0001, t16pwm_pkg::RESP_SLVERR);
    oe(2'h2, 1'b0, 1'b1);
    oe(2'h0, 1'b1, 1'b1);
    oe(2'h2, 1'b1, 1'b0);
    pwm(4'h5, 2'h2, 3'h1, 16'h0040, 16'h0000, 65, 191);
    pwm(4'h5, 2'h3, 3'h1, 16'h0040, 16'h0000, 191, 65);
    pwm(4'h5, 2'h2, 3'h1, 16'h0000, 16'h0000, 1, 255);
    pwm(4'h6, 2'h2, 3'h1, 16'h0100, 16'h0000, 257, 255);
    pwm(4'h7, 2'h2, 3'h1, 16'h0200, 16'h0000, 513, 511);
    pwm(4'he, 2'h2, 3'h1, 16'h0001, 16'h0003, 2, 2);
    pwm(4'hf, 2'h1, 3'h1, 16'h0009, 16'h0000, 10, 10);
    pwm(4'h5, 2'h2, 3'h2, 16'h0040, 16'h0000, 520, 1528);
    pwm(4'h1, 2'h2, 3'h1, 16'h0040, 16'h0000, 128, 382);
    pwm(4'h1, 2'h3, 3'h1, 16'h0040, 16'h0000, 382, 128);
    pwm(4'h2, 2'h2, 3'h1, 16'h0100, 16'h0000, 512, 510);
    pwm(4'h3, 2'h2, 3'h1, 16'h0200, 16'h0000, 1024, 1022);
    pwm(4'ha, 2'h2, 3'h1, 16'h0008, 16'h0010, 16, 16);
    flat(4'h5, 2'h2, 16'h00ff, 1'b1);
    flat(4'h1, 2'h2, 16'h0000, 1'b0);
    flat(4'h1, 2'h2, 16'h00ff, 1'b1);
    flat(4'h1, 2'h3, 16'h0000, 1'b1);
    flat(4'hb, 2'h2, 16'h0020, 1'b1);
    mask(4'h5, 16'h00ff);
    mask(4'h6, 16'h01ff);
    mask(4'h3, 16'h03ff);
    flags(4'he);
    flags(4'ha);
    cap_top();
    final_report();
  end
endmodule
`default_nettype wire
